//--- verilog/cif_top.sv
// Notes on behaviour
// (R01) Bus wake-up activity sets flag bit 14.
// (R02) CAN bus error sets flag bit 13.
// (R03) System-bus fault sets flag bit 12.
// (R04) Bit 12 clears only by off-then-on.
// (R05) Message arriving into full buffer sets bit 11.
// (R06) Mode reaching requested mode sets bit 3.
// (R07) Stamp timer wrap sets bit 2.
// (R08) Bits 1/0 show receive/transmit pending.
// (R09) FIFO select routes match; codes 16-31 reserved.
// (R10) Mask select picks one of four masks.
// (R11) Disabled filter never produces a match.
// (R12) Filters 12, 13, 14 fixed bit layout.
// (R13) Field writes ignored while filter enabled.
// (R14) Flags stay set until cleared.
// (R15) Unused flag bits read zero, ignore writes.
`timescale 1ns/1ps
`include "cif_regs.svh"
module cif_top #(
    parameter int TMR_W = 16
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,

    input wire logic wake_activity_i,
    input wire logic bus_error_i,
    input wire logic sysbus_fault_i,
    input wire logic rx_msg_arrive_i,
    input wire logic rx_buf_full_i,
    input wire logic rx_pending_i,
    input wire logic tx_pending_i,
    input wire logic mode_ready_i,
    input wire logic filter14_on_i,
    input wire logic [2:0] filter_hit_i,

    output logic irq_o,
    output logic module_on_o,
    output cif_pkg::cif_mode_t requested_op_mode_o,
    output cif_pkg::cif_mode_t current_op_mode_o,
    output logic [TMR_W-1:0] stamp_timer_o,
    output logic [2:0] filter_on_o,
    output logic [5:0] filter_mask_sel_o,
    output logic [14:0] filter_fifo_sel_o,
    output logic accept_o,
    output cif_pkg::cif_fifo_t accept_fifo_o
);
    import cif_pkg::*;

    // Maps a byte address to a register; used by both write and read paths.
    function automatic cif_sel_t decode(input logic [7:0] a);
        unique case (a)
            `CIF_OFF_FLAGS: decode = CIF_SEL_FLAGS;
            `CIF_OFF_CLEAR: decode = CIF_SEL_CLEAR;
            `CIF_OFF_IEN: decode = CIF_SEL_IEN;
            `CIF_OFF_FLT3: decode = CIF_SEL_FLT3;
            `CIF_OFF_CTRL: decode = CIF_SEL_CTRL;
            `CIF_OFF_STATE: decode = CIF_SEL_STATE;
            default: decode = CIF_SEL_NONE;
        endcase
    endfunction

    // Expands byte strobes into a bit mask.
    function automatic logic [31:0] lanes(input logic [3:0] s);
        lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    logic wr;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, wr_bits, rd_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_ok;
    cif_sel_t wsel, rsel;

    cif_axil_slave #(
        .AW(8)
    ) u_bus (
        .mclk_i,
        .reset_n_i,
        .awaddr_i,
        .awvalid_i,
        .awready_o,
        .wdata_i,
        .wstrb_i,
        .wvalid_i,
        .wready_o,
        .bresp_o,
        .bvalid_o,
        .bready_i,
        .araddr_i,
        .arvalid_i,
        .arready_o,
        .rdata_o,
        .rresp_o,
        .rvalid_o,
        .rready_i,
        .wr_o(wr),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .wr_ok_i(wr_ok),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_ok_i(rd_ok)
    );

    // Decode and strobe-masked write data.
    assign wsel = decode(wr_addr);
    assign rsel = decode(rd_addr);
    assign wr_ok = (wsel != CIF_SEL_NONE);
    assign rd_ok = (rsel != CIF_SEL_NONE);
    assign wr_bits = wr_data & lanes(wr_strb);

    logic [31:0] flags_reg, flags_next;
    logic [31:0] ien_reg, ien_next;
    logic on_reg, on_next;
    cif_mode_t req_reg, req_next;
    cif_mode_t cur_reg, cur_next;
    logic [TMR_W-1:0] tmr_reg, tmr_next;
    logic irq_reg, irq_next;

    logic mode_switch;
    logic tmr_wrap;
    logic reenable;
    logic [31:0] ev;
    logic [31:0] clr;

    // Control and operating-mode state.
    always_comb begin
        on_next = on_reg;
        req_next = req_reg;
        cur_next = cur_reg;
        mode_switch = 1'b0;
        if (wr && wsel == CIF_SEL_CTRL) begin
            if (wr_strb[1]) begin
                on_next = wr_data[`CIF_B_ON];
            end
            if (wr_strb[3]) begin
                req_next = wr_data[`CIF_REQUESTED_OP_MODE_LSB +: 3];
            end
        end

        // The engine signals when a requested mode may be entered.
        if (mode_ready_i && cur_reg != req_reg) begin
            cur_next = req_reg;
            mode_switch = 1'b1; // R06
        end
    end

    assign reenable = on_next && !on_reg;

    // The stamp timer runs while the module is on.
    always_comb begin
        tmr_next = tmr_reg;
        tmr_wrap = 1'b0;
        if (on_reg) begin
            tmr_next = tmr_reg + 1'b1;
            tmr_wrap = &tmr_reg; // R07
        end
    end

    // Events for this cycle, one per flag position.
    always_comb begin
        ev = '0;

        ev[`CIF_B_WAKE] = wake_activity_i; // R01
        ev[`CIF_B_BUSERR] = bus_error_i; // R02
        ev[`CIF_B_SYSERR] = sysbus_fault_i; // R03
        ev[`CIF_B_RXOVF] = rx_msg_arrive_i && rx_buf_full_i; // R05
        ev[`CIF_B_MODE] = mode_switch; // R06
        ev[`CIF_B_TMRW] = tmr_wrap; // R07
        ev[`CIF_B_RXP] = rx_pending_i; // R08
        ev[`CIF_B_TXP] = tx_pending_i; // R08
    end

    // Sticky flags: an event in the clearing cycle wins over the clear.
    always_comb begin
        clr = '0;
        if (wr && wsel == CIF_SEL_CLEAR) begin
            clr = wr_bits;
        end
        clr[`CIF_B_SYSERR] = reenable; // R04

        flags_next = ((flags_reg & ~clr) | ev) & `CIF_FLAGS_MASK; // R14 R15

        ien_next = ien_reg;
        if (wr && wsel == CIF_SEL_IEN) begin
            ien_next = ((ien_reg & ~lanes(wr_strb)) | wr_bits) & `CIF_FLAGS_MASK;
        end

        irq_next = |(flags_next & ien_next);
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            flags_reg <= '0;
            ien_reg <= '0;
            on_reg <= 1'b0;
            req_reg <= `CIF_MODE_RST;
            cur_reg <= `CIF_MODE_RST;
            tmr_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            ien_reg <= ien_next;
            on_reg <= on_next;
            req_reg <= req_next;
            cur_reg <= cur_next;
            tmr_reg <= tmr_next;
            irq_reg <= irq_next;
        end
    end

    // Filters 12, 13 and 14 live in byte lanes 0, 1 and 2.
    logic [2:0] acc;
    logic [23:0] flt_rd;

    for (genvar i = 0; i < 3; i++) begin : g_flt
        cif_msel_t ms;
        cif_fifo_t fs;
        cif_filter_slot #(
            .HAS_CTRL(i < 2)
        ) u_slot (
            .mclk_i,
            .reset_n_i,
            .wr_i(wr && wsel == CIF_SEL_FLT3 && wr_strb[i]), // R13
            .field_i(wr_data[8*i +: 8]), // R12
            .ext_on_i(filter14_on_i),
            .hit_i(filter_hit_i[i]),
            .on_o(filter_on_o[i]),
            .mask_sel_o(ms),
            .fifo_sel_o(fs),
            .accept_o(acc[i])
        );
        assign filter_mask_sel_o[2*i +: 2] = ms;
        assign filter_fifo_sel_o[5*i +: 5] = fs;

        if (i < 2) begin : g_full
            assign flt_rd[8*i +: 8] = {filter_on_o[i], ms, fs}; // R12
        end else begin : g_fsel
            assign flt_rd[8*i +: 8] = {3'h0, fs}; // R12
        end
    end

    // The lowest-numbered accepting filter chooses the FIFO.
    always_comb begin
        accept_fifo_o = '0;

        if (acc[0]) begin
            accept_fifo_o = filter_fifo_sel_o[4:0]; // R09
        end else if (acc[1]) begin
            accept_fifo_o = filter_fifo_sel_o[9:5];
        end else if (acc[2]) begin
            accept_fifo_o = filter_fifo_sel_o[14:10];
        end
    end

    assign accept_o = |acc; // R11

    // Read multiplexer; the clear register reads as zero.
    always_comb begin
        rd_data = '0;

        unique case (rsel)
            CIF_SEL_FLAGS: rd_data = flags_reg; // R15
            CIF_SEL_IEN: rd_data = ien_reg;
            CIF_SEL_FLT3: rd_data = {8'h00, flt_rd};
            CIF_SEL_CTRL: begin
                rd_data[`CIF_B_ON] = on_reg;
                rd_data[`CIF_REQUESTED_OP_MODE_LSB +: 3] = req_reg;
            end
            CIF_SEL_STATE: begin
                rd_data[`CIF_CUROP_LSB +: 3] = cur_reg;
                rd_data[`CIF_TMR_LSB +: 16] = 16'(tmr_reg);
            end
            CIF_SEL_CLEAR, CIF_SEL_NONE: rd_data = '0;
        endcase
    end

    // Outputs come straight from registers.
    assign irq_o = irq_reg;
    assign module_on_o = on_reg;
    assign requested_op_mode_o = req_reg;
    assign current_op_mode_o = cur_reg;
    assign stamp_timer_o = tmr_reg;
endmodule // cif_top

//--- verilog/cif_regs.svh
`ifndef CIF_REGS_SVH
`define CIF_REGS_SVH
// Register byte offsets.
`define CIF_OFF_FLAGS 8'h00
`define CIF_OFF_CLEAR 8'h04
`define CIF_OFF_IEN 8'h08
`define CIF_OFF_FLT3 8'h0C
`define CIF_OFF_CTRL 8'h10
`define CIF_OFF_STATE 8'h14
// Event flag positions.
`define CIF_B_WAKE 14
`define CIF_B_BUSERR 13
`define CIF_B_SYSERR 12
`define CIF_B_RXOVF 11
`define CIF_B_MODE 3
`define CIF_B_TMRW 2
`define CIF_B_RXP 1
`define CIF_B_TXP 0
`define CIF_FLAGS_MASK 32'h0000780F
// Control and state fields.
`define CIF_B_ON 15
`define CIF_REQUESTED_OP_MODE_LSB 24
`define CIF_CUROP_LSB 0
`define CIF_TMR_LSB 16
`define CIF_MODE_RST 3'h0
// Filter byte layout.
`define CIF_FLT_EN 7
`define CIF_FLT_MSEL_LSB 5
`define CIF_FLT_FSEL_RSV 4
// Bus responses.
`define CIF_RESP_OKAY 2'h0
`define CIF_RESP_SLVERR 2'h2
`endif

//--- verilog/cif_pkg.sv
package cif_pkg;
    typedef logic [2:0] cif_mode_t;
    typedef logic [4:0] cif_fifo_t;
    typedef logic [1:0] cif_msel_t;
    typedef enum logic [2:0] {
        CIF_SEL_FLAGS,
        CIF_SEL_CLEAR,
        CIF_SEL_IEN,
        CIF_SEL_FLT3,
        CIF_SEL_CTRL,
        CIF_SEL_STATE,
        CIF_SEL_NONE
    } cif_sel_t;
endpackage

//--- verilog/cif_filter_slot.sv
`timescale 1ns/1ps
`include "cif_regs.svh"
module cif_filter_slot #(
    parameter bit HAS_CTRL = 1'b1
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic wr_i,
    input wire logic [7:0] field_i,
    input wire logic ext_on_i,
    input wire logic hit_i,
    output logic on_o,
    output cif_pkg::cif_msel_t mask_sel_o,
    output cif_pkg::cif_fifo_t fifo_sel_o,
    output logic accept_o
);
    import cif_pkg::*;

    logic on_reg, on_next;
    cif_msel_t msel_reg, msel_next;
    cif_fifo_t fsel_reg, fsel_next;
    logic live;

    // The fields take a write only while the filter is switched off.
    always_comb begin
        on_next = on_reg;
        msel_next = msel_reg;
        fsel_next = fsel_reg;
        if (wr_i && !live) begin // R13
            fsel_next = field_i[4:0];
            if (HAS_CTRL) begin
                on_next = field_i[`CIF_FLT_EN];
                msel_next = field_i[`CIF_FLT_MSEL_LSB +: 2];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            on_reg <= 1'b0;
            msel_reg <= '0;
            fsel_reg <= '0;
        end else begin
            on_reg <= on_next;
            msel_reg <= msel_next;
            fsel_reg <= fsel_next;
        end
    end

    // A disabled filter or a reserved FIFO code never accepts.
    assign live = HAS_CTRL ? on_reg : ext_on_i;
    assign on_o = live; // R11
    assign mask_sel_o = msel_reg; // R10
    assign fifo_sel_o = fsel_reg; // R09
    assign accept_o = hit_i && live && !fsel_reg[`CIF_FLT_FSEL_RSV]; // R09 R11
endmodule // cif_filter_slot

//--- verilog/cif_axil_slave.sv
`timescale 1ns/1ps
`include "cif_regs.svh"
module cif_axil_slave #(
    parameter int AW = 8
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [AW-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [AW-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic wr_o,
    output logic [AW-1:0] wr_addr_o,
    output logic [31:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    input wire logic wr_ok_i,
    output logic [AW-1:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_ok_i
);
    logic awh_reg, awh_next, wh_reg, wh_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [31:0] data_reg, data_next;
    logic [3:0] strb_reg, strb_next;
    logic bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0] br_reg, br_next, rr_reg, rr_next;
    logic [31:0] rd_reg, rd_next;

    // Address and data are held separately; the write fires when both are in.
    assign awready_o = !awh_reg && !bv_reg;
    assign wready_o = !wh_reg && !bv_reg;
    assign arready_o = !rv_reg;
    assign wr_o = awh_reg && wh_reg && !bv_reg;
    assign wr_addr_o = addr_reg;
    assign wr_data_o = data_reg;
    assign wr_strb_o = strb_reg;
    assign rd_addr_o = araddr_i;

    // Channel state for the next edge.
    always_comb begin
        awh_next = awh_reg;
        wh_next = wh_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        strb_next = strb_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        rv_next = rv_reg;
        rr_next = rr_reg;
        rd_next = rd_reg;
        if (awvalid_i && awready_o) begin
            awh_next = 1'b1;
            addr_next = awaddr_i;
        end
        if (wvalid_i && wready_o) begin
            wh_next = 1'b1;
            data_next = wdata_i;
            strb_next = wstrb_i;
        end
        if (wr_o) begin
            awh_next = 1'b0;
            wh_next = 1'b0;
            bv_next = 1'b1;
            br_next = wr_ok_i ? `CIF_RESP_OKAY : `CIF_RESP_SLVERR;
        end else if (bv_reg && bready_i) begin
            bv_next = 1'b0;
        end
        if (arvalid_i && arready_o) begin
            rv_next = 1'b1;
            rd_next = rd_data_i;
            rr_next = rd_ok_i ? `CIF_RESP_OKAY : `CIF_RESP_SLVERR;
        end else if (rv_reg && rready_i) begin
            rv_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            awh_reg <= 1'b0;
            wh_reg <= 1'b0;
            addr_reg <= '0;
            data_reg <= '0;
            strb_reg <= '0;
            bv_reg <= 1'b0;
            br_reg <= '0;
            rv_reg <= 1'b0;
            rr_reg <= '0;
            rd_reg <= '0;
        end else begin
            awh_reg <= awh_next;
            wh_reg <= wh_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            strb_reg <= strb_next;
            bv_reg <= bv_next;
            br_reg <= br_next;
            rv_reg <= rv_next;
            rr_reg <= rr_next;
            rd_reg <= rd_next;
        end
    end

    assign bvalid_o = bv_reg;
    assign bresp_o = br_reg;
    assign rvalid_o = rv_reg;
    assign rresp_o = rr_reg;
    assign rdata_o = rd_reg;
endmodule // cif_axil_slave

//--- bench/cif_top_monitor.sv
`timescale 1ns/1ps
module cif_top_monitor #(
    parameter int TMR_W = 16
) (
    input logic mclk_i,
    input logic reset_n_i,
    input logic awvalid_i,
    input logic awready_o,
    input logic wvalid_i,
    input logic wready_o,
    input logic bvalid_o,
    input logic arvalid_i,
    input logic arready_o,
    input logic [31:0] rdata_o,
    input logic rvalid_o,
    input logic rready_i,
    input logic mode_ready_i,
    input logic filter14_on_i,
    input logic [2:0] filter_hit_i,
    input logic irq_o,
    input logic module_on_o,
    input cif_pkg::cif_mode_t requested_op_mode_o,
    input cif_pkg::cif_mode_t current_op_mode_o,
    input logic [TMR_W-1:0] stamp_timer_o,
    input logic [2:0] filter_on_o,
    input logic [5:0] filter_mask_sel_o,
    input logic [14:0] filter_fifo_sel_o,
    input logic accept_o,
    input cif_pkg::cif_fifo_t accept_fifo_o
);
    import cif_pkg::*;
    // All checks run on the single clock and sleep during reset.
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    chk_irq_drop_write: assert property ($fell(irq_o) |-> $rose(bvalid_o))
        else $error("irq fell without write");
    chk_mode_follow: assert property ($changed(current_op_mode_o) |->
        $past(mode_ready_i) && current_op_mode_o == $past(requested_op_mode_o))
        else $error("mode moved without cause");
    chk_timer_step: assert property ($past(module_on_o) && module_on_o |->
        stamp_timer_o == TMR_W'($past(stamp_timer_o) + 1'b1))
        else $error("timer step wrong");
    chk_accept_gate: assert property (accept_o |->
        |(filter_hit_i & {filter14_on_i, filter_on_o[1:0]}))
        else $error("accept without hit");
    chk_accept_low: assert property (filter_hit_i[0] && filter_on_o[0] &&
        !filter_fifo_sel_o[4] |-> accept_o && accept_fifo_o == filter_fifo_sel_o[4:0])
        else $error("filter 12 not routed");
    chk_lock_low: assert property ($past(filter_on_o[0]) |-> $stable(filter_on_o[0]) &&
        $stable(filter_mask_sel_o[1:0]) && $stable(filter_fifo_sel_o[4:0]))
        else $error("filter 12 changed");
    chk_lock_high: assert property ($past(filter14_on_i) |->
        $stable(filter_fifo_sel_o[14:10]))
        else $error("filter 14 changed");
    chk_write_answer: assert property (awvalid_i && awready_o && wvalid_i && wready_o
        |-> ##2 bvalid_o)
        else $error("write answer late");
    chk_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
        else $error("read answer late");
    chk_read_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
        else $error("read data moved");
    cover property (accept_o);
    cover property ($rose(irq_o));
    cover property ($changed(current_op_mode_o));
endmodule // cif_top_monitor
bind cif_top cif_top_monitor #(.TMR_W(TMR_W)) cif_top_monitor_inst (.*);

//--- bench/cif_can_node_model.sv
`timescale 1ns/1ps
module cif_can_node_model (
    input logic mclk_i,
    input logic [6:0] ev_i,
    input logic [2:0] hit_i,
    input logic [3:0] lag_i,
    input cif_pkg::cif_mode_t req_mode_i,
    input cif_pkg::cif_mode_t cur_mode_i,
    output logic [6:0] ev_o,
    output logic [2:0] hit_o,
    output logic mode_ready_o
);
    import cif_pkg::*;
    logic [3:0] wait_reg = 4'h0;
    // Events and raw hits reach the design one clock after the request.
    always_ff @(posedge mclk_i) begin
        ev_o <= ev_i;
        hit_o <= hit_i;
    end
    // A mode switch is confirmed only after lag_i clocks of settling.
    always_ff @(posedge mclk_i) begin
        if (req_mode_i == cur_mode_i) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != lag_i) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
    assign mode_ready_o = (req_mode_i != cur_mode_i) && (wait_reg == lag_i);
endmodule // cif_can_node_model

//--- bench/test_can_irq_flags_and_filter_ctl.sv
`timescale 1ns/1ps
`include "cif_regs.svh"
module test_can_irq_flags_and_filter_ctl;
    import cif_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o, module_on_o, accept_o;
    logic [1:0] bresp_o, rresp_o;
    logic [31:0] rdata_o;
    logic [6:0] ev_req = 7'h00, ev;
    logic [2:0] hit_req = 3'h0, hits, filter_on_o;
    logic [3:0] lag = 4'h0;
    logic f14_on = 1'b0, mode_ready;
    cif_mode_t req_mode, cur_mode;
    logic [3:0] timer;
    logic [5:0] msel;
    logic [14:0] fsel;
    cif_fifo_t acc_fifo;
    int num_errors = 0;
    int n_tests = 0;
    cif_top #(.TMR_W(4)) cif_top_inst (.mclk_i, .reset_n_i, .awaddr_i, .awvalid_i, .awready_o,
        .wdata_i, .wstrb_i(4'hF), .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
        .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
        .wake_activity_i(ev[0]), .bus_error_i(ev[1]), .sysbus_fault_i(ev[2]),
        .rx_msg_arrive_i(ev[3]), .rx_buf_full_i(ev[4]), .rx_pending_i(ev[5]),
        .tx_pending_i(ev[6]), .mode_ready_i(mode_ready), .filter14_on_i(f14_on),
        .filter_hit_i(hits), .irq_o, .module_on_o, .requested_op_mode_o(req_mode),
        .current_op_mode_o(cur_mode), .stamp_timer_o(timer), .filter_on_o,
        .filter_mask_sel_o(msel), .filter_fifo_sel_o(fsel), .accept_o, .accept_fifo_o(acc_fifo));
    cif_can_node_model cif_can_node_model_inst (.mclk_i, .ev_i(ev_req), .hit_i(hit_req),
        .lag_i(lag), .req_mode_i(req_mode), .cur_mode_i(cur_mode), .ev_o(ev), .hit_o(hits),
        .mode_ready_o(mode_ready));
    // Free-running 20 MHz clock.
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic guard(inout int n);
        n++;
        if (n > 100) begin
            num_errors++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            end_of_test();
        end
    endtask
    // Bus tasks sample handshakes in the low phase.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        logic aw_hs, w_hs, b_hs;
        awaddr_i <= a;
        wdata_i <= d;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        do begin
            @(negedge mclk_i);
            aw_hs = awvalid_i && awready_o;
            w_hs = wvalid_i && wready_o;
            b_hs = bvalid_o;
            if (b_hs) cmp({30'h0, bresp_o}, {30'h0, er}, "write response");
            @(posedge mclk_i);
            if (aw_hs) awvalid_i <= 1'b0;
            if (w_hs) wvalid_i <= 1'b0;
            if (b_hs) bready_i <= 1'b0;
            guard(n);
        end while (!b_hs);
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                      input string what);
        int n = 0;
        logic ar_hs, r_hs;
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        do begin
            @(negedge mclk_i);
            ar_hs = arvalid_i && arready_o;
            r_hs = rvalid_o;
            if (r_hs) cmp(rdata_o, ed, what);
            if (r_hs) cmp({30'h0, rresp_o}, {30'h0, er}, "read response");
            @(posedge mclk_i);
            if (ar_hs) arvalid_i <= 1'b0;
            if (r_hs) rready_i <= 1'b0;
            guard(n);
        end while (!r_hs);
        @(posedge mclk_i);
    endtask
    task automatic fire(input logic [6:0] e);
        ev_req <= e;
        @(posedge mclk_i);
        ev_req <= 7'h00;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic irq_is(input logic e);
        @(negedge mclk_i);
        cmp({31'h0, irq_o}, {31'h0, e}, "irq level");
        @(posedge mclk_i);
    endtask
    task automatic hit(input logic [2:0] h, input logic ea, input logic [4:0] ef);
        hit_req <= h;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        cmp({26'h0, accept_o, acc_fifo}, {26'h0, ea, ef}, "accept route");
        @(posedge mclk_i);
        hit_req <= 3'h0;
        @(posedge mclk_i);
    endtask
    task automatic t_reset();
        irq_is(1'b0);
        rd(`CIF_OFF_FLAGS, 32'h0, `CIF_RESP_OKAY, "reset flags");
        rd(`CIF_OFF_FLT3, 32'h0, `CIF_RESP_OKAY, "reset filters");
        rd(`CIF_OFF_STATE, 32'h0, `CIF_RESP_OKAY, "reset state");
        rd(8'h18, 32'h0, `CIF_RESP_SLVERR, "unmapped");
        wr(8'h18, 32'hFFFFFFFF, `CIF_RESP_SLVERR);
        rd(`CIF_OFF_CLEAR, 32'h0, `CIF_RESP_OKAY, "clear reads");
    endtask
    task automatic t_events();
        logic [6:0] e[6] = '{7'h01, 7'h02, 7'h18, 7'h20, 7'h40, 7'h08};
        logic [31:0] f[6] = '{32'h4000, 32'h2000, 32'h0800, 32'h0002, 32'h0001, 32'h0};
        wr(`CIF_OFF_IEN, 32'hFFFFFFFF, `CIF_RESP_OKAY);
        rd(`CIF_OFF_IEN, 32'h0000780F, `CIF_RESP_OKAY, "enables");
        for (int i = 0; i < 6; i++) begin
            fire(e[i]);
            rd(`CIF_OFF_FLAGS, f[i], `CIF_RESP_OKAY, "flag set");
            irq_is(f[i] != 32'h0);
            wr(`CIF_OFF_CLEAR, 32'hFFFFFFFF, `CIF_RESP_OKAY);
            rd(`CIF_OFF_FLAGS, 32'h0, `CIF_RESP_OKAY, "cleared");
        end
        fire(7'h02);
        wr(`CIF_OFF_IEN, 32'h0, `CIF_RESP_OKAY);
        irq_is(1'b0);
        wr(`CIF_OFF_IEN, 32'h00002000, `CIF_RESP_OKAY);
        irq_is(1'b1);
        wr(`CIF_OFF_CLEAR, 32'h00002000, `CIF_RESP_OKAY);
        irq_is(1'b0);
    endtask
    task automatic t_fault_and_timer();
        fire(7'h04);
        wr(`CIF_OFF_CLEAR, 32'h00001000, `CIF_RESP_OKAY);
        rd(`CIF_OFF_FLAGS, 32'h1000, `CIF_RESP_OKAY, "fault survives clear");
        wr(`CIF_OFF_CTRL, 32'h00008000, `CIF_RESP_OKAY);
        rd(`CIF_OFF_FLAGS, 32'h0, `CIF_RESP_OKAY, "fault cleared by on");
        wr(`CIF_OFF_CTRL, 32'h0, `CIF_RESP_OKAY);
        wr(`CIF_OFF_CLEAR, 32'h4, `CIF_RESP_OKAY);
        rd(`CIF_OFF_FLAGS, 32'h0, `CIF_RESP_OKAY, "no wrap while off");
        wr(`CIF_OFF_CTRL, 32'h00008000, `CIF_RESP_OKAY);
        repeat (20) @(posedge mclk_i);
        rd(`CIF_OFF_FLAGS, 32'h4, `CIF_RESP_OKAY, "timer wrap");
        wr(`CIF_OFF_CTRL, 32'h0, `CIF_RESP_OKAY);
        wr(`CIF_OFF_CLEAR, 32'h4, `CIF_RESP_OKAY);
    endtask
    task automatic t_mode();
        int n;
        for (int i = 0; i < 2; i++) begin
            n = 0;
            lag <= (i == 0) ? 4'h5 : 4'h0;
            wr(`CIF_OFF_CTRL, (i == 0) ? 32'h03000000 : 32'h05000000, `CIF_RESP_OKAY);
            do begin
                @(negedge mclk_i);
                guard(n);
            end while (cur_mode !== ((i == 0) ? 3'h3 : 3'h5));
            @(posedge mclk_i);
            rd(`CIF_OFF_FLAGS, 32'h8, `CIF_RESP_OKAY, "mode flag");
            wr(`CIF_OFF_CLEAR, 32'h8, `CIF_RESP_OKAY);
        end
    endtask
    task automatic t_filter();
        for (int k = 0; k < 4; k++) begin
            wr(`CIF_OFF_FLT3, {16'h0, 1'b0, 2'(k), 5'h0F, 8'h00}, `CIF_RESP_OKAY);
            cmp({30'h0, msel[3:2]}, 32'(k), "mask select");
        end
        wr(`CIF_OFF_FLT3, 32'h000F7FC5, `CIF_RESP_OKAY);
        rd(`CIF_OFF_FLT3, 32'h000F7FC5, `CIF_RESP_OKAY, "filter layout");
        cmp({17'h0, fsel}, {17'h0, 5'h0F, 5'h1F, 5'h05}, "fifo fields");
        cmp({26'h0, filter_on_o[1:0], msel[3:0]}, 32'h0000001E, "enables");
        hit(3'b011, 1'b1, 5'h05);
        hit(3'b010, 1'b0, 5'h00);
        wr(`CIF_OFF_FLT3, 32'h000FFF01, `CIF_RESP_OKAY);
        rd(`CIF_OFF_FLT3, 32'h000FFFC5, `CIF_RESP_OKAY, "locked byte kept");
        hit(3'b010, 1'b0, 5'h00);
        f14_on <= 1'b1;
        hit(3'b100, 1'b1, 5'h0F);
        hit(3'b111, 1'b1, 5'h05);
        wr(`CIF_OFF_FLT3, 32'h00030000, `CIF_RESP_OKAY);
        rd(`CIF_OFF_FLT3, 32'h000FFFC5, `CIF_RESP_OKAY, "filter 14 locked");
    endtask
    // Reset for 16 clocks, then each scenario.
    initial begin
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        t_reset();
        t_events();
        t_fault_and_timer();
        t_mode();
        t_filter();
        end_of_test();
    end
endmodule // test_can_irq_flags_and_filter_ctl
